/* File: core/scpf_regs.vh */
/*
 * constants of the card property field bank: byte indices into the
 * extended configuration space, bus offsets, field positions, codes.
 * assumes inclusion by bare name from the core/ design files.
 */
`ifndef SCPF_REGS_VH
`define SCPF_REGS_VH

// ----------------------------------------------------------------
// byte indices of the property fields in the 512-byte space
// ----------------------------------------------------------------
`define SCPF_IDX_BOOT_CAPABILITY_INFO     9'd228
`define SCPF_IDX_BOOT_SIZE     9'd226
`define SCPF_IDX_PROG_UNIT     9'd225
`define SCPF_IDX_LG_ERASE_UNIT 9'd224
`define SCPF_IDX_LG_ERASE_TMO  9'd223
`define SCPF_IDX_ATOMIC_WR     9'd222
`define SCPF_IDX_LG_PROT_GRP   9'd221
`define SCPF_IDX_SLEEP_CORE    9'd220
`define SCPF_IDX_SLEEP_IO      9'd219
`define SCPF_IDX_SLEEP_WAKE    9'd217
`define SCPF_IDX_SECTORS_3     9'd215
`define SCPF_IDX_SECTORS_0     9'd212
`define SCPF_IDX_THRU_FIRST    9'd205
`define SCPF_IDX_THRU_LAST     9'd210
`define SCPF_IDX_PWR_FIRST     9'd200
`define SCPF_IDX_PWR_LAST      9'd203
`define SCPF_IDX_PWR_52_360    9'd202
`define SCPF_IDX_PWR_52_195    9'd200
`define SCPF_IDX_ERASE_DEF     9'd175

// ----------------------------------------------------------------
// control and status words of the register port (byte addresses)
// ----------------------------------------------------------------
`define SCPF_ADDR_BYTE_BASE  12'h000
`define SCPF_ADDR_BYTE_LAST  12'h7fc
`define SCPF_ADDR_CTRL       12'h800
`define SCPF_ADDR_STATUS     12'h804
`define SCPF_ADDR_ERASE_UNIT 12'h808
`define SCPF_ADDR_PROT_GRP   12'h80c
`define SCPF_ADDR_ERASE_TMO  12'h810

// ----------------------------------------------------------------
// field positions, codes and reset values
// ----------------------------------------------------------------
`define SCPF_ALT_BOOT_BIT    0
`define SCPF_ERASE_DEF_BIT   0
`define SCPF_ERASE_DEF_RST   1'b0
`define SCPF_PROG_UNIT_MAX   4'h8
`define SCPF_SLEEP_CUR_MAX   8'h0d
`define SCPF_SLEEP_WAKE_MAX  8'h17
`define SCPF_THRU_LOW_CAT    8'h1e
`define SCPF_THRU_MID_CAT    8'h46
`define SCPF_PWR_CLASS_MAX   4'ha
`define SCPF_ERASE_UNIT_KB   32'd512
`define SCPF_LARGE_TMO_MS    32'd300

`endif

/* File: core/scpf_field_check.v */
/*
 * checks one byte of the property space against its legal codes and
 * returns the byte with illegal or reserved content forced to zero.
 * assumes the byte index is stable with the byte.
 */
`timescale 1ns/10ps
`include "scpf_regs.vh"

module scpf_field_check (
   // byte under test
   input  wire [8:0] idx,
   input  wire [7:0] raw,
   // cleaned byte and legality
   output reg  [7:0] clean,
   output reg        legal
);

   // ------------------------------------------------------------
   // legal throughput class codes
   // ------------------------------------------------------------
   function thru_ok;
      input [7:0] c;
      begin
         case (c)
            8'h00, 8'h08, 8'h0a, 8'h0f, 8'h14, 8'h1e, 8'h28, 8'h32,
            8'h3c, 8'h46, 8'h50, 8'h64, 8'h78, 8'h8c,
            8'ha0:   thru_ok = 1'b1;
            default: thru_ok = 1'b0;
         endcase
      end
   endfunction

   // per-field masking; reserved bits read zero
   always @* begin
      clean = raw;
      legal = 1'b1;
      if (idx == `SCPF_IDX_BOOT_CAPABILITY_INFO) begin
         clean = {7'h00, raw[`SCPF_ALT_BOOT_BIT]};
      end else if (idx == `SCPF_IDX_PROG_UNIT) begin
         legal = (raw[3:0] <= `SCPF_PROG_UNIT_MAX);
         clean = legal ? {4'h0, raw[3:0]} : 8'h00;
      end else if (idx == `SCPF_IDX_SLEEP_CORE ||
                   idx == `SCPF_IDX_SLEEP_IO) begin
         legal = (raw <= `SCPF_SLEEP_CUR_MAX);
         clean = legal ? raw : 8'h00;
      end else if (idx == `SCPF_IDX_SLEEP_WAKE) begin
         legal = (raw <= `SCPF_SLEEP_WAKE_MAX);
         clean = legal ? raw : 8'h00;
      end else if (idx >= `SCPF_IDX_THRU_FIRST &&
                   idx <= `SCPF_IDX_THRU_LAST) begin
         legal = thru_ok(raw);
         clean = legal ? raw : 8'h00;
      end else if (idx >= `SCPF_IDX_PWR_FIRST &&
                   idx <= `SCPF_IDX_PWR_LAST) begin
         // high nibble 8-bit bus, low nibble 4-bit bus
         legal = (raw[7:4] <= `SCPF_PWR_CLASS_MAX) &&
                 (raw[3:0] <= `SCPF_PWR_CLASS_MAX);
         clean = legal ? raw : 8'h00;
      end else if (idx == `SCPF_IDX_ATOMIC_WR) begin
         legal = (raw != 8'h00);
      end
   end

endmodule

/* File: core/scpf_group_calc.v */
/*
 * works out the effective erase unit, protect group and erase timeout
 * from the large-unit fields and the erase-definition select bit.
 * assumes the fields are constant; results are combinational.
 */
`timescale 1ns/10ps
`include "scpf_regs.vh"

module scpf_group_calc (
   // selection and fields
   input  wire        sel_large,
   input  wire [7:0]  erase_unit,
   input  wire [7:0]  prot_grp,
   input  wire [7:0]  tmo_mult,
   // effective definitions (kilobytes and milliseconds)
   output wire        use_large_erase,
   output wire        use_large_prot,
   output wire        use_large_tmo,
   output wire [31:0] erase_unit_kb,
   output wire [31:0] prot_grp_kb,
   output wire [31:0] erase_tmo_ms
);

   // large definitions only when selected and the field is nonzero
   assign use_large_erase = sel_large && (erase_unit != 8'h00);
   assign use_large_prot  = use_large_erase &&
                            (prot_grp != 8'h00);
   assign use_large_tmo   = sel_large && (tmo_mult != 8'h00);

   // zero result means the legacy definition applies
   assign erase_unit_kb = use_large_erase ?
          `SCPF_ERASE_UNIT_KB * {24'h000000, erase_unit} : 32'h0;
   assign prot_grp_kb   = use_large_prot ?
          `SCPF_ERASE_UNIT_KB * {24'h000000, erase_unit} *
          {24'h000000, prot_grp} : 32'h0;
   assign erase_tmo_ms  = use_large_tmo ?
          `SCPF_LARGE_TMO_MS * {24'h000000, tmo_mult} : 32'h0;

endmodule

/* File: core/scpf_property_bank.v */
/*
 * read-only property bank of the card's extended configuration space
 * plus the host-written erase-definition select byte.
 * assumes a single 250 MHz clock, a synchronous active-high reset and
 * a register port master that never overlaps its strobes.
 */
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/10ps
`include "scpf_regs.vh"

// Behaviour
// - boot byte bit 0 flags alternate boot support; bits 7:1 read zero
// - boot partition size in 128 kB units; zero means no boot support
// - program unit is 512 B times 2^(v-1); 0 undefined; 9-15 reserved
// - with select set, erase unit is 512 kB times the unit field
// - with select set, one large group erases within 300 ms times mult
// - timeout multiple zero means the legacy erase timeout applies
// - atomic write count is nonzero; single sector always supported
// - with select set, protect group is 512 kB times unit times group
// - select clear or group field zero keeps legacy protect sizing
// - sleep currents are 1 uA times 2^v; above 13 reserved
// - sleep/wake time is 100 ns times 2^v; above 23 reserved
// - sector count is four bytes, least significant at byte 212
// - throughput fields hold only the defined class codes
// - above class 0x1e implies low 0x1e; above 0x46 implies mid 0x46
// - power class high nibble is 8-bit bus, low nibble 4-bit bus
// - default power class 0 covers full speed on a 1-bit bus
// - a 26 MHz device leaves its 52 MHz power classes undefined
// - power class codes 11 to 15 are never reported
// - select bit 0 picks large definitions; resets to legacy
// - reserved bits and bytes read zero
module scpf_property_bank #(
   parameter [7:0]  ALT_BOOT       = 8'h01,
   parameter [7:0]  BOOT_PARTITION_SIZE_MULTIPLE = 8'h01,
   parameter [7:0]  PROG_UNIT      = 8'h01,
   parameter [7:0]  LG_ERASE_UNIT  = 8'h01,
   parameter [7:0]  LG_ERASE_TMO   = 8'h01,
   parameter [7:0]  ATOMIC_WR_CNT  = 8'h01,
   parameter [7:0]  LG_PROT_GRP    = 8'h01,
   parameter [7:0]  SLEEP_CORE     = 8'h01,
   parameter [7:0]  SLEEP_IO       = 8'h01,
   parameter [7:0]  SLEEP_WAKE     = 8'h01,
   parameter [31:0] SECTOR_COUNT   = 32'h00001000,
   parameter [7:0]  THRU_W_8_52    = 8'h00,
   parameter [7:0]  THRU_R_8_52    = 8'h00,
   parameter [7:0]  THRU_W_MID     = 8'h00,
   parameter [7:0]  THRU_R_MID     = 8'h00,
   parameter [7:0]  THRU_W_LOW     = 8'h00,
   parameter [7:0]  THRU_R_LOW     = 8'h00,
   parameter [7:0]  PWR_26_360     = 8'h00,
   parameter [7:0]  PWR_52_360     = 8'h00,
   parameter [7:0]  PWR_26_195     = 8'h00,
   parameter [7:0]  PWR_52_195     = 8'h00,
   parameter        MAX_CLK_52     = 1
) (
   // clock and reset
   input  wire        clk,
   input  wire        rst,
   // register port
   input  wire [11:0] addr,
   input  wire [31:0] wdata,
   input  wire        wr,
   input  wire        rd,
   output reg  [31:0] rdata,
   // effective erase and protect definitions
   output reg         large_defs_active,
   output reg  [31:0] erase_unit_kb,
   output reg  [31:0] prot_grp_kb,
   output reg  [31:0] erase_tmo_ms
);

   // ------------------------------------------------------------
   // constant property image
   // ------------------------------------------------------------
   // only these bytes carry content; everything else reads zero
   function [7:0] prop_byte;
      input [8:0] i;
      begin
         case (i)
            `SCPF_IDX_BOOT_CAPABILITY_INFO:     prop_byte = ALT_BOOT;
            `SCPF_IDX_BOOT_SIZE:     prop_byte = BOOT_PARTITION_SIZE_MULTIPLE;
            `SCPF_IDX_PROG_UNIT:     prop_byte = PROG_UNIT;
            `SCPF_IDX_LG_ERASE_UNIT: prop_byte = LG_ERASE_UNIT;
            `SCPF_IDX_LG_ERASE_TMO:  prop_byte = LG_ERASE_TMO;
            `SCPF_IDX_ATOMIC_WR:     prop_byte = ATOMIC_WR_CNT;
            `SCPF_IDX_LG_PROT_GRP:   prop_byte = LG_PROT_GRP;
            `SCPF_IDX_SLEEP_CORE:    prop_byte = SLEEP_CORE;
            `SCPF_IDX_SLEEP_IO:      prop_byte = SLEEP_IO;
            `SCPF_IDX_SLEEP_WAKE:    prop_byte = SLEEP_WAKE;
            9'd212:  prop_byte = SECTOR_COUNT[7:0];
            9'd213:  prop_byte = SECTOR_COUNT[15:8];
            9'd214:  prop_byte = SECTOR_COUNT[23:16];
            `SCPF_IDX_SECTORS_3: prop_byte = SECTOR_COUNT[31:24];
            9'd210:  prop_byte = THRU_W_8_52;
            9'd209:  prop_byte = THRU_R_8_52;
            9'd208:  prop_byte = THRU_W_MID;
            9'd207:  prop_byte = THRU_R_MID;
            9'd206:  prop_byte = THRU_W_LOW;
            9'd205:  prop_byte = THRU_R_LOW;
            9'd203:  prop_byte = PWR_26_360;
            // 26 MHz parts report no 52 MHz class
            `SCPF_IDX_PWR_52_360:
               prop_byte = (MAX_CLK_52 != 0) ? PWR_52_360 : 8'h00;
            9'd201:  prop_byte = PWR_26_195;
            `SCPF_IDX_PWR_52_195:
               prop_byte = (MAX_CLK_52 != 0) ? PWR_52_195 : 8'h00;
            default: prop_byte = 8'h00;
         endcase
      end
   endfunction

   // ------------------------------------------------------------
   // host-written select and status
   // ------------------------------------------------------------
   reg        erase_def_sel;
   reg [7:0]  bad_count;
   reg [8:0]  scan_idx;
   reg        scan_done;
   reg        cat_ok;

   wire [8:0] rd_idx = addr[10:2];
   wire       in_bytes = (addr[11] == 1'b0);
   wire [7:0] raw_byte = prop_byte(rd_idx);
   wire [7:0] scan_raw = prop_byte(scan_idx);
   wire [7:0] rd_clean;
   wire       scan_legal;

   wire        g_large_erase;
   wire        g_large_prot;
   wire        g_large_tmo;
   wire [31:0] g_erase_kb;
   wire [31:0] g_prot_kb;
   wire [31:0] g_tmo_ms;

   // ------------------------------------------------------------
   // field checkers: one on the read path, one on the self-scan
   // ------------------------------------------------------------
   scpf_field_check u_rd_check (
      .idx   (rd_idx),
      .raw   (raw_byte),
      .clean (rd_clean),
      .legal ()
   );

   scpf_field_check u_scan_check (
      .idx   (scan_idx),
      .raw   (scan_raw),
      .clean (),
      .legal (scan_legal)
   );

   scpf_group_calc u_calc (
      .sel_large       (erase_def_sel),
      .erase_unit      (LG_ERASE_UNIT),
      .prot_grp        (LG_PROT_GRP),
      .tmo_mult        (LG_ERASE_TMO),
      .use_large_erase (g_large_erase),
      .use_large_prot  (g_large_prot),
      .use_large_tmo   (g_large_tmo),
      .erase_unit_kb   (g_erase_kb),
      .prot_grp_kb     (g_prot_kb),
      .erase_tmo_ms    (g_tmo_ms)
   );

   // ------------------------------------------------------------
   // throughput category consistency
   // ------------------------------------------------------------
   // faster classes must also promise the low and mid categories
   function cat_check;
      input [7:0] best;
      input [7:0] mid;
      input [7:0] low;
      begin
         cat_check = 1'b1;
         if (best > `SCPF_THRU_LOW_CAT && low < `SCPF_THRU_LOW_CAT)
            cat_check = 1'b0;
         if (best > `SCPF_THRU_MID_CAT && mid < `SCPF_THRU_MID_CAT)
            cat_check = 1'b0;
      end
   endfunction

   // ------------------------------------------------------------
   // select register; property bytes ignore writes
   // ------------------------------------------------------------
   always @(posedge clk) begin
      if (rst) begin
         erase_def_sel <= `SCPF_ERASE_DEF_RST;
      end else if (wr && addr == `SCPF_ADDR_CTRL) begin
         erase_def_sel <= wdata[`SCPF_ERASE_DEF_BIT];
      end else if (wr && in_bytes &&
                   rd_idx == `SCPF_IDX_ERASE_DEF) begin
         erase_def_sel <= wdata[`SCPF_ERASE_DEF_BIT];
      end
      // writes to any property byte fall through untouched
   end

   // ------------------------------------------------------------
   // background scan counting illegal manufacture-time codes
   // ------------------------------------------------------------
   // runs once after reset; a nonzero count flags a bad build
   always @(posedge clk) begin
      if (rst) begin
         scan_idx  <= 9'h000;
         scan_done <= 1'b0;
         bad_count <= 8'h00;
      end else if (!scan_done) begin
         if (!scan_legal && bad_count != 8'hff)
            bad_count <= bad_count + 8'h01;
         if (scan_idx == 9'h1ff)
            scan_done <= 1'b1;
         scan_idx <= scan_idx + 9'h001;
      end
   end

   // category check of both read and write throughput sets
   always @(posedge clk) begin
      if (rst) begin
         cat_ok <= 1'b1;
      end else begin
         cat_ok <= cat_check(THRU_W_8_52, THRU_W_MID, THRU_W_LOW) &&
                   cat_check(THRU_R_8_52, THRU_R_MID, THRU_R_LOW);
      end
   end

   // ------------------------------------------------------------
   // effective definitions, registered for the outputs
   // ------------------------------------------------------------
   always @(posedge clk) begin
      if (rst) begin
         large_defs_active <= 1'b0;
         erase_unit_kb     <= 32'h0;
         prot_grp_kb       <= 32'h0;
         erase_tmo_ms      <= 32'h0;
      end else begin
         large_defs_active <= g_large_erase;
         erase_unit_kb     <= g_erase_kb;
         prot_grp_kb       <= g_prot_kb;
         erase_tmo_ms      <= g_tmo_ms;
      end
   end

   // ------------------------------------------------------------
   // read data, valid the cycle after the read strobe
   // ------------------------------------------------------------
   always @(posedge clk) begin
      if (rst) begin
         rdata <= 32'h0;
      end else if (rd) begin
         if (in_bytes) begin
            if (rd_idx == `SCPF_IDX_ERASE_DEF)
               rdata <= {31'h0, erase_def_sel};
            else
               rdata <= {24'h000000, rd_clean};
         end else begin
            case (addr)
               `SCPF_ADDR_CTRL:
                  rdata <= {31'h0, erase_def_sel};
               `SCPF_ADDR_STATUS:
                  rdata <= {20'h00000, bad_count, cat_ok, g_large_tmo,
                            g_large_prot, scan_done};
               `SCPF_ADDR_ERASE_UNIT: rdata <= g_erase_kb;
               `SCPF_ADDR_PROT_GRP:   rdata <= g_prot_kb;
               `SCPF_ADDR_ERASE_TMO:  rdata <= g_tmo_ms;
               default:               rdata <= 32'h0;
            endcase
         end
      end else begin
         rdata <= 32'h0;
      end
   end

endmodule

/* File: verification/scpf_bank_checker.sv */
/* assertions on the property bank ports.
   assumes one clock and a synchronous active-high reset. */
`timescale 1ns/10ps
module scpf_bank_checker (
   // clock and reset
   input wire        clk,
   input wire        rst,
   // register port
   input wire [11:0] addr,
   input wire [31:0] wdata,
   input wire        wr,
   input wire        rd,
   input wire [31:0] rdata,
   // derived definitions
   input wire        large_defs_active,
   input wire [31:0] erase_unit_kb,
   input wire [31:0] prot_grp_kb,
   input wire [31:0] erase_tmo_ms
);
   // ------------------------------------------------------------
   // read-back codes, then derived definitions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_boot_rsvd: assert property (
      rd && addr == 12'h390 |=> rdata[31:1] == 31'h0)
      else $error("boot byte reserved bits set");
   a_prog_unit: assert property (
      rd && addr == 12'h384 |=> rdata[31:4] == 28'h0 && rdata[3:0] <= 4'h8)
      else $error("program unit code out of range");
   a_sleep_cur: assert property (
      rd && (addr == 12'h370 || addr == 12'h36c) |=> rdata <= 32'hd)
      else $error("sleep current code reserved");
   a_wake_code: assert property (
      rd && addr == 12'h364 |=> rdata <= 32'h17)
      else $error("sleep wake code reserved");
   a_pwr_nibble: assert property (
      rd && addr >= 12'h320 && addr <= 12'h32c |=> rdata[31:8] == 24'h0
      && rdata[7:4] <= 4'ha && rdata[3:0] <= 4'ha)
      else $error("power class code reserved");
   a_unmapped_zero: assert property (
      rd && addr > 12'h810 |=> rdata == 32'h0)
      else $error("unmapped read not zero");
   a_legacy_sizes: assert property (
      !large_defs_active |-> erase_unit_kb == 32'h0 && prot_grp_kb == 32'h0)
      else $error("large sizes shown while legacy");
   a_large_unit: assert property (
      large_defs_active |-> erase_unit_kb != 32'h0
      && erase_unit_kb[8:0] == 9'h0)
      else $error("erase unit not a 512 kB multiple");
   a_select_cause: assert property (
      $rose(large_defs_active) |-> $past(wr, 2)
      && ($past(addr, 2) == 12'h2bc || $past(addr, 2) == 12'h800))
      else $error("large definitions without a select write");
   a_reset_legacy: assert property (
      $fell(rst) |-> !large_defs_active && erase_tmo_ms == 32'h0)
      else $error("large definitions after reset");
   a_tmo_step: assert property (
      erase_tmo_ms % 32'd300 == 32'h0)
      else $error("erase timeout not a 300 ms multiple");
endmodule

bind scpf_property_bank scpf_bank_checker i_chk (
   .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata(rdata), .large_defs_active(large_defs_active),
   .erase_unit_kb(erase_unit_kb), .prot_grp_kb(prot_grp_kb),
   .erase_tmo_ms(erase_tmo_ms));

/* File: verification/scpf_host_model.sv */
/* host side of the register port: single-cycle strobes.
   assumes tasks are entered just after a rising clock edge. */
`timescale 1ns/10ps
module scpf_host_model (
   // clock
   input  wire         clk,
   // register port towards the bank
   output logic [11:0] addr,
   output logic [31:0] wdata,
   output logic        wr,
   output logic        rd
);
   // ------------------------------------------------------------
   // bus cycles
   // ------------------------------------------------------------
   initial begin
      addr = 12'h0;
      wdata = 32'h0;
      wr = 1'b0;
      rd = 1'b0;
   end
   // one write; also how the host picks erase definitions
   task automatic put(input [11:0] a, input [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      rd <= 1'b0;
      @(posedge clk);
   endtask
   // one read; no lowering, so calls may run back to back
   task automatic get(input [11:0] a);
      addr <= a;
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge clk);
   endtask
   // release: flip address and data so nothing stale looks valid
   task automatic idle();
      addr <= ~addr;
      wdata <= ~wdata;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk);
   endtask
   // total wait the host allows for several large groups
   function automatic [31:0] total_tmo(input [31:0] per, input [7:0] n);
      total_tmo = per * n;
   endfunction
endmodule

/* File: verification/scpf_property_bank_bench.sv */
/* self-checking bench of the property bank.
   assumes the host model and the checker bound to the bank. */
`timescale 1ns/10ps
`include "scpf_regs.vh"
module scpf_property_bank_bench;
   localparam [7:0] UNIT = 8'h02;
   localparam [7:0] GRP  = 8'h03;
   localparam [7:0] TMO  = 8'h04;
   // part image under test; a few bytes carry illegal codes on purpose
   localparam [7:0]  P_BOOT = 8'hff, P_BSIZE = 8'h80, P_PUNIT = 8'h38;
   localparam [7:0]  P_ATOM = 8'h01, P_SCORE = 8'h0e, P_SIO = 8'h0d;
   localparam [7:0]  P_SWAKE = 8'h17, P_TW852 = 8'h0b, P_TR852 = 8'ha0;
   localparam [7:0]  P_TRMID = 8'h46, P_TRLOW = 8'h1e, P_PW26A = 8'hab;
   localparam [7:0]  P_PW52A = 8'h11, P_PW26B = 8'h5a;
   localparam [31:0] P_SECS = 32'h12345678;
   localparam int    P_CLK52 = 0;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   wire  [11:0] addr;
   wire  [31:0] wdata;
   wire         wr;
   wire         rd;
   wire  [31:0] rdata;
   wire         large_defs_active;
   wire  [31:0] erase_unit_kb;
   wire  [31:0] prot_grp_kb;
   wire  [31:0] erase_tmo_ms;
   int          mismatches = 0;
   int          n_checks = 0;
   int          rnd;
   logic        pend = 1'b0;
   logic [31:0] expq[$];
   // property byte index and its expected read value
   int unsigned idx_t[24] = '{228, 227, 226, 225, 224, 223, 222, 221,
      220, 219, 218, 217, 216, 215, 214, 213, 212, 210, 209, 207, 205,
      203, 202, 201};
   logic [7:0]  exp_t[24] = '{8'h01, 8'h00, 8'h80, 8'h08, UNIT, TMO,
      8'h01, GRP, 8'h00, 8'h0d, 8'h00, 8'h17, 8'h00, 8'h12, 8'h34, 8'h56,
      8'h78, 8'h00, 8'ha0, 8'h46, 8'h1e, 8'h00, 8'h00, 8'h5a};

   // ------------------------------------------------------------
   // clock, design, host
   // ------------------------------------------------------------
   always #2 clk = ~clk;
   scpf_property_bank #(.ALT_BOOT(P_BOOT), .BOOT_PARTITION_SIZE_MULTIPLE(P_BSIZE),
      .PROG_UNIT(P_PUNIT), .LG_ERASE_UNIT(UNIT), .LG_ERASE_TMO(TMO),
      .ATOMIC_WR_CNT(P_ATOM), .LG_PROT_GRP(GRP), .SLEEP_CORE(P_SCORE),
      .SLEEP_IO(P_SIO), .SLEEP_WAKE(P_SWAKE), .SECTOR_COUNT(P_SECS),
      .THRU_W_8_52(P_TW852), .THRU_R_8_52(P_TR852), .THRU_R_MID(P_TRMID),
      .THRU_R_LOW(P_TRLOW), .PWR_26_360(P_PW26A), .PWR_52_360(P_PW52A),
      .PWR_26_195(P_PW26B), .MAX_CLK_52(P_CLK52)) i_dut (
      .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .large_defs_active(large_defs_active),
      .erase_unit_kb(erase_unit_kb), .prot_grp_kb(prot_grp_kb),
      .erase_tmo_ms(erase_tmo_ms));
   scpf_host_model i_host (.clk(clk), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd));

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_bit(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t flag %b expected %b", $time, got, exp);
      end
   endtask
   task automatic rd_exp(input [11:0] a, input [31:0] e);
      expq.push_back(e);
      i_host.get(a);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // pairs each read strobe with the oldest note in the queue
   always @(posedge clk) begin
      if (pend)
         cmp(rdata, expq.pop_front());
      pend <= rd && !rst;
   end
   // cut a hang short well past the expected run length
   initial begin
      #20000;
      mismatches++;
      $display("[ERR] %0t watchdog expired", $time);
      tally_and_finish();
   end

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   initial begin
      rnd = $urandom(40);
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      cmp_bit(large_defs_active, 1'b0);
      for (int i = 0; i < 24; i++)
         rd_exp(12'(idx_t[i] * 4), {24'h0, exp_t[i]});
      rd_exp(12'hffc, 32'h0);
      // writes to fixed bytes must leave every byte as it was
      repeat (8)
         i_host.put(12'($urandom_range(200, 228) * 4), $urandom);
      for (int i = 0; i < 24; i++)
         rd_exp(12'(idx_t[i] * 4), {24'h0, exp_t[i]});
      // let the post-reset self-scan finish, then read its verdict
      i_host.idle();
      repeat (520) @(posedge clk);
      rd_exp(`SCPF_ADDR_STATUS, 32'h00000039);
      i_host.put(12'h2bc, 32'hffffffff);
      rd_exp(12'h2bc, 32'h1);
      rd_exp(`SCPF_ADDR_CTRL, 32'h1);
      i_host.idle();
      #1;
      cmp_bit(large_defs_active, 1'b1);
      cmp(erase_unit_kb, 512 * UNIT);
      cmp(prot_grp_kb, 512 * UNIT * GRP);
      cmp(erase_tmo_ms, 300 * TMO);
      cmp(i_host.total_tmo(erase_tmo_ms, 8'd3), 900 * TMO);
      rd_exp(`SCPF_ADDR_ERASE_UNIT, 512 * UNIT);
      rd_exp(`SCPF_ADDR_PROT_GRP, 512 * UNIT * GRP);
      rd_exp(`SCPF_ADDR_ERASE_TMO, 300 * TMO);
      i_host.put(`SCPF_ADDR_CTRL, 32'h0);
      i_host.idle();
      i_host.idle();
      #1;
      cmp_bit(large_defs_active, 1'b0);
      cmp(prot_grp_kb, 32'h0);
      cmp(erase_tmo_ms, 32'h0);
      // a reset in mid-run drops the select back to legacy
      i_host.put(12'h2bc, 32'h1);
      i_host.idle();
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      rd_exp(12'h2bc, 32'h0);
      rd_exp(12'h390, 32'h1);
      i_host.idle();
      i_host.idle();
      tally_and_finish();
   end
endmodule
